// *** hw/link_ctrl_map.vh ***
// Purpose: register indices, field positions, reset values of the link control bank
// Assumes: byte address on the bus is four times the register index
// Notes: definitions only
`ifndef LINK_CTRL_MAP_VH
`define LINK_CTRL_MAP_VH

// register indices
`define IDX_EQ_READBACK 8'h3b
`define IDX_LINK_ERR 8'h41
`define IDX_FAST_BC 8'h43
`define IDX_EQ_MANUAL 8'h44
`define IDX_EQ_FLOOR 8'h45
`define IDX_VIDEO_MODE 8'h49
`define IDX_AUX_CTRL 8'h60
`define IDX_LINK_STATUS 8'h61

// link error register fields
`define ERR_EN_BIT 4
`define ERR_THR_RST 4'h3

// fast back-channel fields
`define BC_DRIVE_BIT 4
`define BC_POL_BIT 3
`define BC_MODE_NORMAL 3'h0
`define BC_MODE_GPIO1 3'h1
`define BC_MODE_GPIO2 3'h2
`define BC_MODE_GPIO4 3'h3
`define BC_MODE_FWD_SPI 3'h6
`define BC_MODE_REV_SPI 3'h7

// equalizer manual fields
`define EQ_S1_RST 3'h3
`define EQ_S2_RST 3'h0
`define EQ_BYP_RST 1'h0
`define EQ_FLOOR_RST 4'h8

// video output mode fields
`define VM_STRAP_BIT 7
`define VM_OVR_BIT 6
`define VM_REG_BIT 5
`define ARR_DUAL 2'h0
`define ARR_SWAP 2'h1
`define ARR_SINGLE 2'h2
`define ARR_REPLICA 2'h3

// aux control fields
`define AUX_PORT_BIT 0
`define AUX_FLOOR_BIT 1

// cycles after reset release before the synchronised strap is caught
`define STRAP_WAIT 2'h3

`endif

// *** hw/link_control_register_bank.v ***
// Purpose: configuration and status bank of a serial video link receiver, APB slave
// Assumes: pixel clock is pclk; link error flags and eq values arrive on pclk
// Notes: strap, chip select and spi pins are asynchronous and pass two flops
`timescale 1ns/1ps
`include "link_ctrl_map.vh"

module link_control_register_bank (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire word_valid,
    input wire embedded_clock_bit_first_err,
    input wire embedded_clock_bit_second_err,
    input wire data_control_field_err,
    input wire lock_acquired,
    output reg link_locked,
    input wire [5:0] eq_adaptive_first_port,
    input wire [5:0] eq_adaptive_second_port,
    output reg [5:0] eq_apply_first_port,
    output reg [5:0] eq_apply_second_port,
    output reg [3:0] floor_first_port,
    output reg [3:0] floor_second_port,
    output reg floor_enable,
    output reg [2:0] fast_backchannel_mode,
    output reg forward_spi_active,
    output reg reverse_spi_active,
    output reg [2:0] fast_gpio_count,
    input wire spi_cs_n,
    input wire spi_sclk,
    input wire spi_pico,
    input wire reverse_tx_bit,
    output reg peripheral_out_data,
    output wire peripheral_out_oe_n,
    output reg launch_strobe,
    output reg sample_strobe,
    output reg sampled_bit,
    input wire [2:0] strap_pin_zero,
    input wire strap_bitmap,
    output reg [1:0] video_output_arrangement,
    output reg bitmap_select
);

    // register state
    reg err_count_en;
    reg [3:0] err_threshold;
    reg [3:0] err_count;
    reg peripheral_out_drive_mode;
    reg spi_edge_polarity;
    reg [2:0] bc_mode;
    reg [2:0] eq_first_stage_manual [0:1];
    reg [2:0] eq_second_stage_manual [0:1];
    reg auto_equalizer_bypass [0:1];
    reg [3:0] equalizer_start_floor [0:1];
    reg second_port_select;
    reg equalizer_floor;
    reg strap_sensed;
    reg bitmap_override;
    reg bitmap_reg_bit;
    reg [1:0] arrangement;
    reg [1:0] strap_wait;
    // synchronisers: stage one is read only by stage two
    reg [2:0] strap_s1, strap_s2;
    reg map_s1, map_s2;
    reg cs_s1, cs_s2;
    reg sclk_s1, sclk_s2, sclk_d;
    reg pico_s1, pico_s2;

    wire [7:0] idx = paddr[9:2];
    wire aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    wire sel = second_port_select;
    reg hit;
    wire wr = psel && penable && pwrite && pstrb[0] && hit;
    wire [7:0] wd = pwdata[7:0];

    // applied equalizer setting of one port
    function [5:0] eq_setting;
        input byp;
        input [2:0] s1;
        input [2:0] s2;
        input [5:0] adaptive;
        begin
            eq_setting = byp ? {s2, s1} : adaptive;
        end
    endfunction

    // fast gpio lanes carried by a back-channel mode
    function [2:0] gpio_lanes;
        input [2:0] mode;
        begin
            case (mode)
                `BC_MODE_GPIO1: gpio_lanes = 3'h1;
                `BC_MODE_GPIO2: gpio_lanes = 3'h2;
                `BC_MODE_GPIO4: gpio_lanes = 3'h4;
                default: gpio_lanes = 3'h0;
            endcase
        end
    endfunction

    // address decode; unmapped indices answer with an error
    always @* begin
        case (idx)
            `IDX_EQ_READBACK, `IDX_LINK_ERR, `IDX_FAST_BC, `IDX_EQ_MANUAL,
            `IDX_EQ_FLOOR, `IDX_VIDEO_MODE, `IDX_AUX_CTRL,
            `IDX_LINK_STATUS: hit = aligned;
            default: hit = 1'b0;
        endcase
    end

    // zero wait: read data is prepared in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    // read data latched in the setup phase so it stands through access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            prdata <= 32'h0;
            if (hit && !pwrite) begin
                case (idx)
                    `IDX_EQ_READBACK: prdata[5:0] <= sel ? eq_apply_second_port
                                                       : eq_apply_first_port;
                    `IDX_LINK_ERR: prdata[4:0] <= {err_count_en, err_threshold};
                    `IDX_FAST_BC: prdata[4:0] <= {peripheral_out_drive_mode,
                                                  spi_edge_polarity, bc_mode};
                    `IDX_EQ_MANUAL: prdata[7:0] <= {eq_first_stage_manual[sel], 1'b0,
                                                    eq_second_stage_manual[sel],
                                                    auto_equalizer_bypass[sel]};
                    `IDX_EQ_FLOOR: prdata[3:0] <= equalizer_start_floor[0];
                    `IDX_VIDEO_MODE: prdata[7:0] <= {strap_sensed, bitmap_override,
                                                     bitmap_reg_bit, 3'h0, arrangement};
                    `IDX_AUX_CTRL: prdata[1:0] <= {equalizer_floor, second_port_select};
                    `IDX_LINK_STATUS: prdata[7:0] <= {err_count, 3'h0, link_locked};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    // two-flop synchronisers for every pin input
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_s1 <= 3'h0;
            strap_s2 <= 3'h0;
            map_s1 <= 1'b0;
            map_s2 <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_d <= 1'b0;
            pico_s1 <= 1'b0;
            pico_s2 <= 1'b0;
        end else begin
            strap_s1 <= strap_pin_zero;
            strap_s2 <= strap_s1;
            map_s1 <= strap_bitmap;
            map_s2 <= map_s1;
            cs_s1 <= spi_cs_n;
            cs_s2 <= cs_s1;
            sclk_s1 <= spi_sclk;
            sclk_s2 <= sclk_s1;
            sclk_d <= sclk_s2;
            pico_s1 <= spi_pico;
            pico_s2 <= pico_s1;
        end
    end

    // software registers; strap capture overrides a write in its one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_count_en <= 1'b0;
            err_threshold <= `ERR_THR_RST;
            peripheral_out_drive_mode <= 1'b0;
            spi_edge_polarity <= 1'b0;
            bc_mode <= `BC_MODE_NORMAL;
            eq_first_stage_manual[0] <= `EQ_S1_RST;
            eq_first_stage_manual[1] <= `EQ_S1_RST;
            eq_second_stage_manual[0] <= `EQ_S2_RST;
            eq_second_stage_manual[1] <= `EQ_S2_RST;
            auto_equalizer_bypass[0] <= `EQ_BYP_RST;
            auto_equalizer_bypass[1] <= `EQ_BYP_RST;
            equalizer_start_floor[0] <= `EQ_FLOOR_RST;
            equalizer_start_floor[1] <= `EQ_FLOOR_RST;
            second_port_select <= 1'b0;
            equalizer_floor <= 1'b0;
            bitmap_override <= 1'b0;
            bitmap_reg_bit <= 1'b0;
            strap_sensed <= 1'b0;
            arrangement <= `ARR_DUAL;
            strap_wait <= 2'h0;
        end else begin
            if (wr) begin
                case (idx)
                    `IDX_LINK_ERR: begin
                        err_count_en <= wd[`ERR_EN_BIT];
                        err_threshold <= wd[3:0];
                    end
                    `IDX_FAST_BC: begin
                        peripheral_out_drive_mode <= wd[`BC_DRIVE_BIT];
                        spi_edge_polarity <= wd[`BC_POL_BIT];
                        bc_mode <= wd[2:0];
                    end
                    `IDX_EQ_MANUAL: begin
                        eq_first_stage_manual[sel] <= wd[7:5];
                        eq_second_stage_manual[sel] <= wd[3:1];
                        auto_equalizer_bypass[sel] <= wd[0];
                    end
                    `IDX_EQ_FLOOR: equalizer_start_floor[sel] <= wd[3:0];
                    `IDX_VIDEO_MODE: begin
                        bitmap_override <= wd[`VM_OVR_BIT];
                        bitmap_reg_bit <= wd[`VM_REG_BIT];
                        arrangement <= wd[1:0];
                    end
                    `IDX_AUX_CTRL: begin
                        second_port_select <= wd[`AUX_PORT_BIT];
                        equalizer_floor <= wd[`AUX_FLOOR_BIT];
                    end
                    default: ;
                endcase
            end
            // strap is caught once the synchroniser has filled after release
            if (strap_wait != `STRAP_WAIT) begin
                strap_wait <= strap_wait + 2'h1;
                if (strap_wait == `STRAP_WAIT - 2'h1) begin
                    // low two bits give the arrangement
                    arrangement <= strap_s2[1:0];
                    strap_sensed <= map_s2;
                end
            end
        end
    end

    // link error counter on the pixel clock
    wire word_err = word_valid && (embedded_clock_bit_first_err ||
        embedded_clock_bit_second_err || data_control_field_err);
    wire [4:0] count_inc = {1'b0, err_count} + 5'h1;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_count <= 4'h0;
            link_locked <= 1'b0;
        end else if (lock_acquired) begin
            err_count <= 4'h0;
            link_locked <= 1'b1;
        end else if (link_locked && word_err) begin
            // both clock bits and control field
            if (!err_count_en) begin
                link_locked <= 1'b0;
                err_count <= 4'h0;
            end else if (count_inc >= {1'b0, err_threshold}) begin
                link_locked <= 1'b0;
                err_count <= 4'h0;
            end else begin
                err_count <= count_inc[3:0];
            end
        end
    end

    // reverse spi drive: driven always, or only while chip select is low
    wire rev_mode = (bc_mode == `BC_MODE_REV_SPI);
    assign peripheral_out_oe_n = !(rev_mode && (!peripheral_out_drive_mode || !cs_s2));

    // launch and sample edges follow polarity
    wire rise = sclk_s2 && !sclk_d;
    wire fall = !sclk_s2 && sclk_d;
    wire launch_edge = spi_edge_polarity ? rise : fall;
    wire sample_edge = spi_edge_polarity ? fall : rise;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_out_data <= 1'b0;
            launch_strobe <= 1'b0;
            sample_strobe <= 1'b0;
            sampled_bit <= 1'b0;
        end else begin
            launch_strobe <= launch_edge && !cs_s2;
            sample_strobe <= sample_edge && !cs_s2;
            if (launch_edge && !cs_s2) begin
                peripheral_out_data <= reverse_tx_bit;
            end
            if (sample_edge && !cs_s2) begin
                sampled_bit <= pico_s2;
            end
        end
    end

    // registered outputs steering the link, equalizers and video path
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eq_apply_first_port <= 6'h0;
            eq_apply_second_port <= 6'h0;
            floor_first_port <= `EQ_FLOOR_RST;
            floor_second_port <= `EQ_FLOOR_RST;
            floor_enable <= 1'b0;
            fast_backchannel_mode <= `BC_MODE_NORMAL;
            forward_spi_active <= 1'b0;
            reverse_spi_active <= 1'b0;
            fast_gpio_count <= 3'h0;
            video_output_arrangement <= `ARR_DUAL;
            bitmap_select <= 1'b0;
        end else begin
            eq_apply_first_port <= eq_setting(auto_equalizer_bypass[0],
                eq_first_stage_manual[0], eq_second_stage_manual[0],
                eq_adaptive_first_port);
            eq_apply_second_port <= eq_setting(auto_equalizer_bypass[1],
                eq_first_stage_manual[1], eq_second_stage_manual[1],
                eq_adaptive_second_port);
            // floor seed for the adaptive loop
            floor_first_port <= equalizer_start_floor[0];
            floor_second_port <= equalizer_start_floor[1];
            floor_enable <= equalizer_floor;
            fast_backchannel_mode <= bc_mode;
            forward_spi_active <= (bc_mode == `BC_MODE_FWD_SPI);
            reverse_spi_active <= rev_mode;
            fast_gpio_count <= gpio_lanes(bc_mode);
            video_output_arrangement <= arrangement;
            bitmap_select <= bitmap_override ? bitmap_reg_bit : strap_sensed;
        end
    end

endmodule // link_control_register_bank

// *** dv/link_bank_sva.sv ***
// Purpose: port level checks of the link control bank
// Assumes: one clock pclk, presetn async active low
// Notes: attached by the bind below the module
`timescale 1ns/1ps
module link_bank_sva (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire word_valid,
    input wire embedded_clock_bit_first_err,
    input wire embedded_clock_bit_second_err,
    input wire data_control_field_err,
    input wire lock_acquired,
    input wire link_locked,
    input wire [2:0] fast_backchannel_mode,
    input wire [2:0] fast_gpio_count,
    input wire peripheral_out_oe_n,
    input wire launch_strobe,
    input wire sample_strobe
);
    wire bad_word;
    // errors only count when the word itself is valid
    assign bad_word = word_valid && (embedded_clock_bit_first_err ||
        embedded_clock_bit_second_err || data_control_field_err);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_unmapped;
        psel && penable && paddr == 12'h0f0 |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_err_in_access; pslverr |-> psel && penable; endproperty
    a_err_in_access: assert property (p_err_in_access) else $error("slave error outside access");
    // the enable follows the mode register at once, the mode output one edge later
    property p_oe_mode;
        !peripheral_out_oe_n && !$past(peripheral_out_oe_n) |-> fast_backchannel_mode == 3'h7;
    endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("data out driven outside reverse");
    property p_gpio4;
        fast_backchannel_mode == 3'h3 && $past(fast_backchannel_mode) == 3'h3
            |-> fast_gpio_count == 3'h4;
    endproperty
    a_gpio4: assert property (p_gpio4) else $error("four gpio mode gives wrong count");
    property p_lock_set; lock_acquired |=> link_locked; endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock not taken");
    property p_drop_cause;
        $fell(link_locked) |-> $past(bad_word) || $past(bad_word, 2);
    endproperty
    a_drop_cause: assert property (p_drop_cause) else $error("lock dropped without error");
    property p_unlock_hold; !link_locked && !lock_acquired |=> !link_locked; endproperty
    a_unlock_hold: assert property (p_unlock_hold) else $error("lock rose without acquire");
    property p_strobe_excl; !(launch_strobe && sample_strobe); endproperty
    a_strobe_excl: assert property (p_strobe_excl) else $error("launch and sample together");
    // main scenarios reached
    c_drop: cover property ($fell(link_locked));
    c_refuse: cover property (pslverr);
    c_sample: cover property (sample_strobe);
    c_drive: cover property (!peripheral_out_oe_n);
endmodule // link_bank_sva

bind link_control_register_bank link_bank_sva link_bank_sva_i (.pclk, .presetn, .psel, .penable,
    .paddr, .prdata, .pslverr, .word_valid, .embedded_clock_bit_first_err,
    .embedded_clock_bit_second_err, .data_control_field_err, .lock_acquired, .link_locked,
    .fast_backchannel_mode, .fast_gpio_count, .peripheral_out_oe_n, .launch_strobe,
    .sample_strobe);

// *** dv/remote_ser.sv ***
// Purpose: remote serializer stand-in feeding received words and lock events
// Assumes: words arrive on pclk, one per call
// Notes: error flags show garbage between words, so qualification is exercised
`timescale 1ns/1ps
module remote_ser (
    input wire pclk,
    output logic word_valid,
    output logic embedded_clock_bit_first_err,
    output logic embedded_clock_bit_second_err,
    output logic data_control_field_err,
    output logic lock_acquired
);
    // quiet link at start
    initial {word_valid, data_control_field_err, embedded_clock_bit_second_err,
        embedded_clock_bit_first_err, lock_acquired} = 5'h0e;
    // receiver reports lock for one cycle
    task automatic acquire();
        @(posedge pclk);
        lock_acquired <= 1'b1;
        @(posedge pclk);
        lock_acquired <= 1'b0;
    endtask
    task automatic send(input logic [2:0] errs);
        @(posedge pclk);
        word_valid <= 1'b1;
        {data_control_field_err, embedded_clock_bit_second_err, embedded_clock_bit_first_err} <= errs;
        @(posedge pclk);
        word_valid <= 1'b0;
        {data_control_field_err, embedded_clock_bit_second_err, embedded_clock_bit_first_err} <= ~errs;
    endtask
endmodule // remote_ser

// *** dv/link_control_register_bank_tb_top.sv ***
// Purpose: self checking bench of the link control bank
// Assumes: apb slave with no wait states, straps stable from reset
// Notes: byte address is four times the register index
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module link_control_register_bank_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic spi_cs_n = 1'b1, spi_sclk = 1'b0, spi_pico = 1'b0, reverse_tx_bit = 1'b0;
    logic [5:0] eq_adaptive_first_port = 6'h0, eq_adaptive_second_port = 6'h0;
    logic [2:0] strap_pin_zero = 3'h6;
    logic strap_bitmap = 1'b1;
    wire [31:0] prdata;
    wire pready, pslverr, word_valid, embedded_clock_bit_first_err, embedded_clock_bit_second_err;
    wire data_control_field_err, lock_acquired, link_locked, floor_enable;
    wire [5:0] eq_apply_first_port, eq_apply_second_port;
    wire [3:0] floor_first_port, floor_second_port;
    wire [2:0] fast_backchannel_mode, fast_gpio_count;
    wire forward_spi_active, reverse_spi_active, peripheral_out_data, peripheral_out_oe_n;
    wire launch_strobe, sample_strobe, sampled_bit, bitmap_select;
    wire [1:0] video_output_arrangement;
    int err_total = 0, cmp_count = 0, cycles = 0, n_launch = 0, n_sample = 0;
    logic [11:0] ra [5] = '{12'h104, 12'h10c, 12'h110, 12'h114, 12'h124};
    logic [31:0] rst_v [5] = '{32'h03, 32'h00, 32'h60, 32'h08, 32'h82};
    logic [31:0] ff_v [5] = '{32'h1f, 32'h1f, 32'hef, 32'h0f, 32'he3};

    link_control_register_bank link_control_register_bank_i (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .word_valid,
        .embedded_clock_bit_first_err, .embedded_clock_bit_second_err, .data_control_field_err,
        .lock_acquired, .link_locked, .eq_adaptive_first_port, .eq_adaptive_second_port,
        .eq_apply_first_port, .eq_apply_second_port, .floor_first_port, .floor_second_port,
        .floor_enable, .fast_backchannel_mode, .forward_spi_active, .reverse_spi_active,
        .fast_gpio_count, .spi_cs_n, .spi_sclk, .spi_pico, .reverse_tx_bit, .peripheral_out_data,
        .peripheral_out_oe_n, .launch_strobe, .sample_strobe, .sampled_bit, .strap_pin_zero,
        .strap_bitmap, .video_output_arrangement, .bitmap_select);
    remote_ser remote_ser_i (.pclk, .word_valid, .embedded_clock_bit_first_err,
        .embedded_clock_bit_second_err, .data_control_field_err, .lock_acquired);

    always #5 pclk = ~pclk;
    // watchdog plus spi strobe tallies
    always @(posedge pclk) begin
        cycles++;
        if (launch_strobe === 1'b1) n_launch++;
        if (sample_strobe === 1'b1) n_sample++;
        if (cycles == 5000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // one apb transfer; an idle edge always precedes the setup cycle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
        output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // only the watchdog ends a stalled access
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic t_regs();
        logic [31:0] q;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ra[i], 8'h0, q);
            `CHK(q, rst_v[i])
            wr(ra[i], 8'hff);
            apb(1'b0, ra[i], 8'h0, q);
            `CHK(q, ff_v[i])
        end
        apb(1'b0, 12'h0f0, 8'h0, q);
        `CHK(q, 32'h0)
    endtask
    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            wr(12'h10c, m[7:0]);
            cyc(2);
            `CHK(fast_backchannel_mode, m[2:0])
            `CHK(fast_gpio_count, (m == 1) ? 3'h1 : (m == 2) ? 3'h2 : (m == 3) ? 3'h4 : 3'h0)
            `CHK({forward_spi_active, reverse_spi_active}, {m == 6, m == 7})
        end
    endtask
    task automatic t_lock();
        logic [31:0] q;
        wr(12'h104, 8'h13);
        remote_ser_i.acquire();
        remote_ser_i.send(3'b001);
        remote_ser_i.send(3'b010);
        cyc(2);
        `CHK(link_locked, 1'b1)
        apb(1'b0, 12'h184, 8'h0, q);
        `CHK(q, 32'h21)
        remote_ser_i.send(3'b100);
        cyc(2);
        `CHK(link_locked, 1'b0)
        wr(12'h104, 8'h03);
        remote_ser_i.acquire();
        cyc(1);
        `CHK(link_locked, 1'b1)
        remote_ser_i.send(3'b010);
        cyc(2);
        `CHK(link_locked, 1'b0)
    endtask
    task automatic t_eq();
        logic [31:0] q;
        @(posedge pclk);
        eq_adaptive_first_port <= 6'h11;
        eq_adaptive_second_port <= 6'h2a;
        wr(12'h180, 8'h00);
        wr(12'h110, 8'ha5);
        cyc(2);
        `CHK(eq_apply_first_port, 6'h15)
        apb(1'b0, 12'h0ec, 8'h0, q);
        `CHK(q, 32'h15)
        wr(12'h110, 8'ha4);
        cyc(2);
        `CHK(eq_apply_first_port, 6'h11)
        wr(12'h180, 8'h03);
        wr(12'h110, 8'h27);
        wr(12'h114, 8'h05);
        cyc(2);
        `CHK({eq_apply_second_port, eq_apply_first_port}, 12'h651)
        // first port floor still holds 0xf from the all-ones pass of t_regs
        `CHK({floor_enable, floor_second_port, floor_first_port}, 9'h15f)
        apb(1'b0, 12'h114, 8'h0, q);
        `CHK(q, 32'h0f)
    endtask
    task automatic t_video();
        for (int a = 0; a < 4; a++) begin
            wr(12'h124, {6'h10, a[1:0]});
            cyc(2);
            `CHK({bitmap_select, video_output_arrangement}, {1'b0, a[1:0]})
        end
        wr(12'h124, 8'h00);
        cyc(2);
        `CHK(bitmap_select, 1'b1)
    endtask
    task automatic spi_step(input logic lvl, input int dl, input int ds);
        int l0, s0;
        l0 = n_launch;
        s0 = n_sample;
        @(posedge pclk);
        spi_sclk <= lvl;
        cyc(6);
        `CHK({n_launch - l0, n_sample - s0}, {dl, ds})
    endtask
    task automatic t_spi();
        wr(12'h10c, 8'h17);
        cyc(4);
        `CHK(peripheral_out_oe_n, 1'b1)
        @(posedge pclk);
        spi_cs_n <= 1'b0;
        spi_pico <= 1'b1;
        reverse_tx_bit <= 1'b1;
        cyc(4);
        `CHK(peripheral_out_oe_n, 1'b0)
        spi_step(1'b1, 0, 1);
        spi_step(1'b0, 1, 0);
        `CHK({sampled_bit, peripheral_out_data}, 2'h3)
        wr(12'h10c, 8'h0f);
        spi_step(1'b1, 1, 0);
        spi_step(1'b0, 0, 1);
        @(posedge pclk);
        spi_cs_n <= 1'b1;
        wr(12'h10c, 8'h07);
        cyc(4);
        `CHK(peripheral_out_oe_n, 1'b0)
    endtask
    // reset for four cycles, then let the strap capture settle
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        cyc(6);
        t_regs();
        t_modes();
        t_lock();
        t_eq();
        t_video();
        t_spi();
        print_verdict();
    end
endmodule // link_control_register_bank_tb_top
